// File: logic/dsm_pkg.sv
package dsm_pkg;
	// =====================================================
	// timing
	// =====================================================
	localparam int CLK_HZ = 20_000_000;
	localparam int CONV_CLK_HZ = 400_000; // conversion clock, full scale fits the normal time
	localparam int CONV_DIV = CLK_HZ / CONV_CLK_HZ;
	localparam int UP_PERIODS = 1000;
	localparam int AUTO_RATE_HZ = 5;
	localparam int AUTO_PERIOD = CLK_HZ / AUTO_RATE_HZ;
	localparam int NORMAL_MS = 9;
	localparam int OVERLOAD_MS = 11;
	localparam int OVERLOAD_CYC = (CLK_HZ / 1000) * OVERLOAD_MS;
	localparam int MAX_COUNT = 1999;
	localparam int THOUSAND = 1000;

	// =====================================================
	// types
	// =====================================================
	typedef enum logic [1:0] {
		DSM_IDLE,
		DSM_ARMED,
		DSM_UP,
		DSM_DOWN
	} dsm_state_e;

	typedef struct packed {
		logic [3:0] hundreds;
		logic [3:0] tens;
		logic [3:0] units;
		logic thousand;
	} dsm_count_s;

	typedef struct packed {
		logic suspend_n;
		logic convert_n;
		logic sign_blank_n;
	} dsm_ctrl_s;

	typedef struct packed {
		logic [3:0] bcd_hundreds;
		logic [3:0] bcd_tens;
		logic [3:0] bcd_units;
		logic beyond_thousand;
		logic over_full_scale;
		logic polarity;
		logic sign_lit;
		logic status;
	} dsm_result_s;
endpackage : dsm_pkg

// File: logic/dsm_decade.sv
// =====================================================
// cascaded decimal ramp-down counter
// =====================================================
module dsm_decade (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic step,
	output dsm_pkg::dsm_count_s count,
	output logic full
);
	import dsm_pkg::*;
	dsm_count_s cnt_q, cnt_d;

	// bcd increment of one digit with carry out
	function automatic logic [4:0] dec_inc(input logic [3:0] d, input logic cin);
		logic [4:0] r;
		r = {1'b0, d};
		if (cin) begin
			if (d == 4'h9) begin
				r = 5'h10;
			end else begin
				r = {1'b0, d + 4'h1};
			end
		end
		return r;
	endfunction : dec_inc

	// next count
	always_comb begin
		logic [4:0] u;
		logic [4:0] t;
		logic [4:0] h;
		u = 5'h00;
		t = 5'h00;
		h = 5'h00;
		cnt_d = cnt_q;
		if (clear) begin
			cnt_d = '0;
		end else if (step) begin
			u = dec_inc(cnt_q.units, 1'b1);
			t = dec_inc(cnt_q.tens, u[4]);
			h = dec_inc(cnt_q.hundreds, t[4]);
			cnt_d.units = u[3:0];
			cnt_d.tens = t[3:0];
			cnt_d.hundreds = h[3:0];
			cnt_d.thousand = cnt_q.thousand | h[4];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign count = cnt_q;
	// count sits at 1999
	assign full = cnt_q.thousand && cnt_q.hundreds == 4'h9 && cnt_q.tens == 4'h9
		&& cnt_q.units == 4'h9;
endmodule : dsm_decade

// File: logic/dsm_sequencer.sv
module dsm_sequencer #(
	parameter bit NEG_POLARITY = 1'b0,
	parameter int AUTO_CYCLES = dsm_pkg::AUTO_PERIOD,
	parameter int TICK_CYCLES = dsm_pkg::CONV_DIV
) (
	input wire logic clk,
	input wire logic reset_n,
	input dsm_pkg::dsm_ctrl_s ctrl,
	input wire logic comparator_baseline,
	input wire logic input_positive,
	input wire logic [3:0] point_select_n,
	output logic integrate_up,
	output logic integrate_down,
	output dsm_pkg::dsm_result_s result,
	output logic [3:0] point_lit
);
	import dsm_pkg::*;

	// =====================================================
	// input synchronisers
	// =====================================================
	logic [5:0] meta_q, meta_d;
	logic [5:0] sync_q, sync_d;
	logic suspend_n_s, convert_n_s, sign_blank_n_s, baseline_s, positive_s;
	logic conv_prev_q, conv_prev_d;
	logic [3:0] point_meta_q, point_sync_q;

	always_comb begin
		meta_d = {ctrl.suspend_n, ctrl.convert_n, ctrl.sign_blank_n,
			comparator_baseline, input_positive, 1'b0};
		sync_d = meta_q;
		conv_prev_d = convert_n_s;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= 6'h38;
			sync_q <= 6'h38;
			conv_prev_q <= 1'b1;
			point_meta_q <= 4'hF;
			point_sync_q <= 4'hF;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			conv_prev_q <= conv_prev_d;
			point_meta_q <= point_select_n;
			point_sync_q <= point_meta_q;
		end
	end

	assign suspend_n_s = sync_q[5];
	assign convert_n_s = sync_q[4];
	assign sign_blank_n_s = sync_q[3];
	assign baseline_s = sync_q[2];
	assign positive_s = sync_q[1];

	// pulse edges, gated by hold
	logic trig_fall, trig_rise;
	assign trig_fall = conv_prev_q && !convert_n_s && !suspend_n_s;
	assign trig_rise = !conv_prev_q && convert_n_s && !suspend_n_s;

	// =====================================================
	// conversion clock tick
	// =====================================================
	// divider period sets both phase lengths and so the conversion time
	localparam int DIV_W = $clog2(TICK_CYCLES);
	logic [DIV_W-1:0] div_q, div_d;
	logic tick;

	always_comb begin
		tick = (div_q == DIV_W'(TICK_CYCLES - 1));
		div_d = tick ? '0 : div_q + DIV_W'(1);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// =====================================================
	// sequencer
	// =====================================================
	localparam int AUTO_W = $clog2(AUTO_PERIOD + 1);
	localparam int UP_W = $clog2(UP_PERIODS + 1);

	dsm_state_e state_q, state_d;
	logic [AUTO_W-1:0] auto_q, auto_d;
	logic [UP_W-1:0] up_q, up_d;
	logic armed_q, armed_d;
	logic status_q, status_d;
	logic overload_q, overload_d;
	logic pol_q, pol_d;
	dsm_count_s held_q, held_d;
	dsm_count_s live;
	logic cnt_clear, cnt_step, cnt_full;

	dsm_decade u_decade (
		.clk(clk),
		.reset_n(reset_n),
		.clear(cnt_clear),
		.step(cnt_step),
		.count(live),
		.full(cnt_full)
	);

	// next state of the conversion sequence
	always_comb begin
		state_d = state_q;
		auto_d = auto_q;
		up_d = up_q;
		armed_d = armed_q;
		status_d = status_q;
		overload_d = overload_q;
		pol_d = pol_q;
		held_d = held_q;
		cnt_clear = 1'b0;
		cnt_step = 1'b0;
		case (state_q)
			DSM_IDLE: begin
				// free-running self trigger only while unheld
				if (suspend_n_s) begin
					if (auto_q == AUTO_W'(AUTO_CYCLES - 1)) begin
						auto_d = '0;
						armed_d = 1'b1;
						status_d = 1'b1;
					end else begin
						auto_d = auto_q + AUTO_W'(1);
					end
				end else begin
					auto_d = '0;
				end
				if (trig_fall) begin
					status_d = 1'b1;
				end
				if (trig_rise && status_q) begin
					armed_d = 1'b1;
				end
				if (armed_q) begin
					state_d = DSM_ARMED;
				end
			end
			DSM_ARMED: begin
				// wait for conversion clock edge, at most one period
				if (tick) begin
					armed_d = 1'b0;
					cnt_clear = 1'b1;
					up_d = '0;
					state_d = DSM_UP;
				end
			end
			DSM_UP: begin
				if (tick) begin
					if (up_q == UP_W'(UP_PERIODS - 1)) begin
						state_d = DSM_DOWN;
					end else begin
						up_d = up_q + UP_W'(1);
					end
				end
			end
			DSM_DOWN: begin
				if (baseline_s || (tick && cnt_full)) begin
					overload_d = !baseline_s && cnt_full;
					pol_d = NEG_POLARITY ? !positive_s : positive_s;
					held_d = live;
					status_d = 1'b0;
					state_d = DSM_IDLE;
				end else if (tick) begin
					cnt_step = 1'b1;
				end
			end
			default: begin
				state_d = DSM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= DSM_IDLE;
			auto_q <= '0;
			up_q <= '0;
			armed_q <= 1'b0;
			status_q <= 1'b0;
			overload_q <= 1'b0;
			pol_q <= 1'b0;
			held_q <= '0;
		end else begin
			state_q <= state_d;
			auto_q <= auto_d;
			up_q <= up_d;
			armed_q <= armed_d;
			status_q <= status_d;
			overload_q <= overload_d;
			pol_q <= pol_d;
			held_q <= held_d;
		end
	end

	// =====================================================
	// outputs
	// =====================================================
	assign integrate_up = (state_q == DSM_UP);
	assign integrate_down = (state_q == DSM_DOWN);

	// result words follow the held count straight through
	always_comb begin
		result.bcd_hundreds = held_q.hundreds;
		result.bcd_tens = held_q.tens;
		result.bcd_units = held_q.units;
		result.beyond_thousand = held_q.thousand;
		result.over_full_scale = overload_q;
		result.polarity = pol_q;
		result.sign_lit = sign_blank_n_s;
		result.status = status_q;
	end

	assign point_lit = ~point_sync_q;

	// =====================================================
	// checks
	// =====================================================
	// clocks since the sequence left idle
	localparam int NORMAL_CYC = (CLK_HZ / 1000) * NORMAL_MS;
	int unsigned conv_cyc;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_cyc <= 0;
		end else if (state_q == DSM_IDLE) begin
			conv_cyc <= 0;
		end else begin
			conv_cyc <= conv_cyc + 1;
		end
	end

	// clocks spent in the up phase of the current conversion
	int unsigned up_cyc;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			up_cyc <= 0;
		end else if (state_q == DSM_UP) begin
			up_cyc <= up_cyc + 1;
		end else if (state_q == DSM_ARMED) begin
			up_cyc <= 0;
		end
	end

	// status may only drop as ramp-down closes
	property status_valid;
		@(posedge clk) disable iff (!reset_n)
		$fell(status_q) |-> state_q == DSM_IDLE && $past(state_q) == DSM_DOWN;
	endproperty
	status_done_a: assert property (status_valid) else $error("status fell early");

	// convert pin edges, hold and self start
	trigger_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
		trig_fall && state_q == DSM_IDLE |=> status_q) else $error("status not raised");

	rise_arms_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == DSM_IDLE && trig_rise && status_q |=> armed_q)
		else $error("convert rise did not arm");

	hold_no_auto_a: assert property (@(posedge clk) disable iff (!reset_n)
		!suspend_n_s && !trig_rise && state_q == DSM_IDLE && !armed_q |=> !armed_q)
		else $error("self start while held");

	auto_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
		suspend_n_s && state_q == DSM_IDLE && auto_q == AUTO_W'(AUTO_CYCLES - 1)
		|=> status_q && armed_q) else $error("self start missed");

	hold_finish_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == DSM_UP && !suspend_n_s |=> state_q == DSM_UP || state_q == DSM_DOWN)
		else $error("hold cut a conversion");

	// phase lengths, ramp-down end, busy status, capture and overload
	up_length_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(integrate_up) |-> up_q == UP_W'(UP_PERIODS - 1) && integrate_down)
		else $error("up phase length wrong");

	up_exact_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(integrate_up) |-> up_cyc == UP_PERIODS * TICK_CYCLES)
		else $error("up phase clocks wrong");

	baseline_end_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == DSM_DOWN && baseline_s |=> state_q == DSM_IDLE && !status_q)
		else $error("ramp-down not ended");

	busy_status_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_q != DSM_IDLE |-> status_q) else $error("status low while converting");

	capture_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(status_q) |-> held_q == $past(live)) else $error("count not captured");

	overload_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == DSM_DOWN && tick && cnt_full && !baseline_s |=> overload_q)
		else $error("overload missed");

	// conversion time limits
	conv_time_a: assert property (@(posedge clk) disable iff (!reset_n)
		conv_cyc <= OVERLOAD_CYC) else $error("conversion too long");

	conv_normal_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == DSM_DOWN && baseline_s |-> conv_cyc <= NORMAL_CYC)
		else $error("normal conversion too long");

	// sign blank reaches only the lit sign
	sign_blank_a: assert property (@(posedge clk) disable iff (!reset_n)
		result.sign_lit == sign_blank_n_s && $stable(pol_q) |-> $stable(result.polarity))
		else $error("blank touched polarity");

	// main scenarios
	auto_conv_c: cover property (@(posedge clk) disable iff (!reset_n)
		suspend_n_s && $rose(status_q));
	ext_conv_c: cover property (@(posedge clk) disable iff (!reset_n)
		trig_rise && status_q);
	over_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(overload_q));
	held_conv_c: cover property (@(posedge clk) disable iff (!reset_n)
		!suspend_n_s && state_q == DSM_DOWN);
	blank_sign_c: cover property (@(posedge clk) disable iff (!reset_n)
		!sign_blank_n_s && result.polarity);
endmodule : dsm_sequencer

// File: verif/dsm_front_model.sv
// =====================================================
// integrator and comparator stand-in
// =====================================================
module dsm_front_model #(
	parameter int TICK_CYCLES = dsm_pkg::CONV_DIV
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic integrate_up,
	input wire logic integrate_down,
	input wire integer target,
	output logic comparator_baseline,
	output int up_len
);
	timeunit 1ns;
	timeprecision 1ns;
	import dsm_pkg::*;
	int down_cnt;
	logic up_q;

	// count ramp-down clocks and measure the up phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			down_cnt <= 0;
			up_len <= 0;
			up_q <= 1'b0;
		end else begin
			up_q <= integrate_up;
			if (integrate_up) begin
				up_len <= up_q ? up_len + 1 : 1;
			end
			down_cnt <= integrate_down ? down_cnt + 1 : 0;
		end
	end

	// back at baseline half a tick past the target count
	assign comparator_baseline = integrate_down
		&& (down_cnt >= target * TICK_CYCLES + TICK_CYCLES / 2);
endmodule : dsm_front_model

// File: verif/tb_dual_slope_meter_sequencer.sv
module tb_dual_slope_meter_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	import dsm_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	dsm_ctrl_s ctrl = 3'b011;
	logic positive = 1'b1;
	logic [3:0] point_sel_n = 4'hF;
	logic baseline;
	logic up;
	logic down;
	dsm_result_s res;
	logic [3:0] lit;
	int target = 0;
	int up_len;
	int fail_count = 0;
	int check_count = 0;
	int cyc;
	localparam int SIM_TICK = 10; // short conversion clock keeps the run brief
	localparam int SIM_AUTO = 5000;

	// =====================================================
	// clock, design and far side
	// =====================================================
	always #25 clk = ~clk;

	dsm_sequencer #(.AUTO_CYCLES(SIM_AUTO), .TICK_CYCLES(SIM_TICK)) dut (
		.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .comparator_baseline(baseline),
		.input_positive(positive), .point_select_n(point_sel_n), .integrate_up(up),
		.integrate_down(down), .result(res), .point_lit(lit));

	dsm_front_model #(.TICK_CYCLES(SIM_TICK)) model (.clk(clk), .reset_n(reset_n),
		.integrate_up(up),
		.integrate_down(down), .target(target), .comparator_baseline(baseline),
		.up_len(up_len));

	// =====================================================
	// tasks
	// =====================================================
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// low-going pulse of 40 clocks (2 us), only while idle
	task automatic trigger;
		@(negedge clk);
		ctrl.convert_n = 1'b0;
		repeat (4) @(negedge clk);
		chk({14'h0, res.status, up}, 16'h2);
		repeat (36) @(negedge clk);
		ctrl.convert_n = 1'b1;
	endtask : trigger

	// bounded wait for status low
	task automatic wait_done;
		cyc = 0;
		while (res.status !== 1'b0 && cyc < 250000) begin
			@(negedge clk);
			cyc++;
		end
		chk({15'h0, res.status}, 16'h0);
	endtask : wait_done

	task automatic check_res(input logic [11:0] bcd, input logic [2:0] flags);
		chk({3'h0, res.bcd_hundreds, res.bcd_tens, res.bcd_units, res.beyond_thousand},
			{3'h0, bcd, flags[2]});
		chk({14'h0, res.over_full_scale, res.polarity}, {14'h0, flags[1:0]});
	endtask : check_res

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// =====================================================
	// tests
	// =====================================================
	initial begin
		repeat (3) @(negedge clk);
		chk({11'h0, res.status, lit}, 16'h0);
		reset_n = 1'b1;
		// held: no self start
		repeat (6000) @(negedge clk);
		chk({15'h0, res.status}, 16'h0);
		// each decimal point select
		for (int i = 0; i < 4; i++) begin
			point_sel_n = ~(4'h1 << i);
			repeat (3) @(negedge clk);
			chk({12'h0, lit}, {12'h0, 4'h1 << i});
		end
		// triggered, positive, 123 counts
		target = 123;
		trigger();
		wait_done();
		chk(16'(up_len), 16'(UP_PERIODS * SIM_TICK));
		check_res(12'h123, 3'b001);
		// sign blank leaves polarity data alone
		ctrl.sign_blank_n = 1'b0;
		repeat (3) @(negedge clk);
		chk({14'h0, res.sign_lit, res.polarity}, 16'h1);
		ctrl.sign_blank_n = 1'b1;
		// overload, negative input, comparator never trips
		target = 3000;
		positive = 1'b0;
		trigger();
		wait_done();
		chk({15'h0, cyc <= (UP_PERIODS + MAX_COUNT + 4) * SIM_TICK}, 16'h1);
		check_res(12'h999, 3'b110);
		// self start, then hold applied mid-conversion
		target = 1042;
		ctrl.suspend_n = 1'b1;
		cyc = 0;
		while (res.status !== 1'b1 && cyc < 6000) begin
			@(negedge clk);
			cyc++;
		end
		chk({15'h0, res.status}, 16'h1);
		chk({15'h0, cyc >= SIM_AUTO}, 16'h1);
		repeat (100) @(negedge clk);
		ctrl.suspend_n = 1'b0;
		wait_done();
		check_res(12'h042, 3'b100);
		repeat (6000) @(negedge clk);
		chk({15'h0, res.status}, 16'h0);
		// convert pulse ignored while unheld
		ctrl.suspend_n = 1'b1;
		repeat (3) @(negedge clk);
		ctrl.convert_n = 1'b0;
		repeat (40) @(negedge clk);
		ctrl.convert_n = 1'b1;
		repeat (4) @(negedge clk);
		chk({15'h0, res.status}, 16'h0);
		wrap_up();
	end

	// watchdog: the tests need about 4 ms
	initial begin
		#5_000_000;
		fail_count++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		wrap_up();
	end
endmodule : tb_dual_slope_meter_sequencer
